// ===== rtl/cmpctl_consts.vh
// Constants for the comparator control and event logic.
// Assumes inclusion by bare name from the design file.
`ifndef CMPCTL_CONSTS_VH
`define CMPCTL_CONSTS_VH

// ----------------------------------------
// Register offsets (byte addresses)
// ----------------------------------------
`define CMPCTL_ADDR_W 4
`define CMPCTL_OFS_CONTROL 4'h0
`define CMPCTL_OFS_STATUS 4'h4
`define CMPCTL_OFS_MASK 4'h8

// ----------------------------------------
// Control word fields
// ----------------------------------------
`define CMPCTL_BIT_ENABLE 15
`define CMPCTL_BIT_PIN_EN 14
`define CMPCTL_BIT_INVERT 13
`define CMPCTL_BIT_RESULT 8
`define CMPCTL_BIT_EDGE_HI 7
`define CMPCTL_BIT_EDGE_LO 6
`define CMPCTL_BIT_POS_REF 4
`define CMPCTL_BIT_NEG_HI 1
`define CMPCTL_BIT_NEG_LO 0
`define CMPCTL_CTRL_WMASK 32'h0000E0D3
`define CMPCTL_CTRL_RESET 32'h000000C3

// ----------------------------------------
// Edge select encodings
// ----------------------------------------
`define CMPCTL_EDGE_NONE 2'h0
`define CMPCTL_EDGE_RISE 2'h1
`define CMPCTL_EDGE_FALL 2'h2
`define CMPCTL_EDGE_BOTH 2'h3

`endif

// ===== rtl/cmpctl_top.v
// Digital control and event logic for one analog comparator.
// Assumes the analog core reports its raw result asynchronously and
// a single-clock register port with read data one cycle after the strobe.
`timescale 1ns/1ns
`include "cmpctl_consts.vh"

module cmpctl_top (
	input wire clock,
	input wire rst,
	input wire [3:0] addr,
	input wire [31:0] wdata,
	input wire wr,
	input wire rd,
	output reg [31:0] rdata,
	input wire raw_result,
	output reg comparator_on,
	output reg positive_input_ref_select,
	output reg [1:0] negative_input_select,
	output reg result_pin,
	output reg result_pin_oe,
	output reg compare_event,
	output reg irq
);

	// ----------------------------------------
	// Reset and mask images
	// ----------------------------------------
	localparam [31:0] CTRL_RESET = `CMPCTL_CTRL_RESET;
	localparam [31:0] CTRL_WMASK = `CMPCTL_CTRL_WMASK;
	localparam [31:0] WORD_ZERO = 32'h00000000;

	// ----------------------------------------
	// Functions
	// ----------------------------------------
	// Strobe qualified by one register offset
	function port_hit;
		input strobe;
		input [3:0] a;
		input [3:0] ofs;
		begin
			port_hit = strobe & (a == ofs);
		end
	endfunction

	// Edge qualifier for the selected event polarity
	function edge_hit;
		input [1:0] sel;
		input prev;
		input cur;
		begin
			case (sel)
				`CMPCTL_EDGE_RISE: edge_hit = ~prev & cur;
				`CMPCTL_EDGE_FALL: edge_hit = prev & ~cur;
				`CMPCTL_EDGE_BOTH: edge_hit = prev ^ cur;
				default: edge_hit = 1'h0;
			endcase
		end
	endfunction

	// Event polarity field of a control word
	function [1:0] ctrl_edge;
		input [31:0] c;
		begin
			ctrl_edge = c[`CMPCTL_BIT_EDGE_HI:`CMPCTL_BIT_EDGE_LO];
		end
	endfunction

	// Negative input field of a control word
	function [1:0] ctrl_neg;
		input [31:0] c;
		begin
			ctrl_neg = c[`CMPCTL_BIT_NEG_HI:`CMPCTL_BIT_NEG_LO];
		end
	endfunction

	// Control image as software reads it
	function [31:0] ctrl_view;
		input [31:0] c;
		input res;
		begin
			ctrl_view = c & CTRL_WMASK;
			ctrl_view[`CMPCTL_BIT_RESULT] = res;
		end
	endfunction

	// One-bit register widened to a bus word
	function [31:0] bit_view;
		input b;
		begin
			bit_view = {31'h00000000, b};
		end
	endfunction

	// ----------------------------------------
	// Registers and nets
	// ----------------------------------------
	reg [31:0] ctrl;
	reg [31:0] next_ctrl;
	reg sync1;
	reg sync2;
	reg result_prev;
	reg status;
	reg next_status;
	reg mask;
	reg next_mask;
	reg next_irq;
	reg next_event;
	reg [31:0] next_rdata;
	wire wr_ctrl;
	wire wr_status;
	wire wr_mask;
	wire rd_ctrl;
	wire rd_status;
	wire rd_mask;
	wire status_clear;
	wire enable;
	wire invert;
	wire pin_drive;
	wire [1:0] edge_sel;
	wire result;
	wire hit;

	// ----------------------------------------
	// Register port decode
	// ----------------------------------------
	assign wr_ctrl = port_hit(wr, addr, `CMPCTL_OFS_CONTROL);
	assign wr_status = port_hit(wr, addr, `CMPCTL_OFS_STATUS);
	assign wr_mask = port_hit(wr, addr, `CMPCTL_OFS_MASK);
	assign rd_ctrl = port_hit(rd, addr, `CMPCTL_OFS_CONTROL);
	assign rd_status = port_hit(rd, addr, `CMPCTL_OFS_STATUS);
	assign rd_mask = port_hit(rd, addr, `CMPCTL_OFS_MASK);
	// Write-one-to-clear on bit 0 only
	assign status_clear = wr_status & wdata[0];

	// ----------------------------------------
	// Control fields
	// ----------------------------------------
	assign enable = ctrl[`CMPCTL_BIT_ENABLE];
	assign invert = ctrl[`CMPCTL_BIT_INVERT];
	assign pin_drive = ctrl[`CMPCTL_BIT_PIN_EN];
	assign edge_sel = ctrl_edge(ctrl);

	// ----------------------------------------
	// Result path
	// ----------------------------------------
	// Disabled comparator reports low, as the analog core is powered off
	assign result = comparator_on & (sync2 ^ invert);
	// Edge taken after inversion, so polarity flips the raw edge used
	assign hit = edge_hit(edge_sel, result_prev, result);

	// ----------------------------------------
	// Next control word
	// ----------------------------------------
	always @* begin
		next_ctrl = ctrl;
		if (wr_ctrl) begin
			next_ctrl = wdata & CTRL_WMASK;
		end
	end

	// ----------------------------------------
	// Next status, mask and interrupt
	// ----------------------------------------
	always @* begin
		next_status = status;
		if (status_clear) begin
			next_status = 1'h0;
		end
		// Event set wins over a simultaneous clear
		if (hit) begin
			next_status = 1'h1;
		end
	end

	always @* begin
		next_mask = mask;
		if (wr_mask) begin
			next_mask = wdata[0];
		end
	end

	always @* begin
		next_irq = next_status & next_mask;
		next_event = hit;
	end

	// ----------------------------------------
	// Next read data
	// ----------------------------------------
	// Read data stands one cycle only, zero otherwise
	always @* begin
		next_rdata = WORD_ZERO;
		if (rd_ctrl) begin
			next_rdata = ctrl_view(ctrl, result);
		end else if (rd_status) begin
			next_rdata = bit_view(status);
		end else if (rd_mask) begin
			next_rdata = bit_view(mask);
		end
	end

	// ----------------------------------------
	// Input synchroniser
	// ----------------------------------------
	// Only the second stage feeds logic, to bound metastability
	always @(posedge clock) begin
		if (rst) begin
			sync1 <= 1'h0;
			sync2 <= 1'h0;
		end else begin
			sync1 <= raw_result;
			sync2 <= sync1;
		end
	end

	// ----------------------------------------
	// Edge detector
	// ----------------------------------------
	// Previous starts low, matching the powered-off result
	always @(posedge clock) begin
		if (rst) begin
			result_prev <= 1'h0;
			compare_event <= 1'h0;
		end else begin
			result_prev <= result;
			compare_event <= next_event;
		end
	end

	// ----------------------------------------
	// Control register
	// ----------------------------------------
	always @(posedge clock) begin
		if (rst) begin
			ctrl <= CTRL_RESET;
		end else begin
			ctrl <= next_ctrl;
		end
	end

	// ----------------------------------------
	// Status, mask and interrupt
	// ----------------------------------------
	always @(posedge clock) begin
		if (rst) begin
			status <= 1'h0;
		end else begin
			status <= next_status;
		end
	end

	always @(posedge clock) begin
		if (rst) begin
			mask <= 1'h0;
		end else begin
			mask <= next_mask;
		end
	end

	always @(posedge clock) begin
		if (rst) begin
			irq <= 1'h0;
		end else begin
			irq <= next_irq;
		end
	end

	// ----------------------------------------
	// Analog core controls
	// ----------------------------------------
	// Core settings lag the control word by one cycle
	always @(posedge clock) begin
		if (rst) begin
			comparator_on <= CTRL_RESET[`CMPCTL_BIT_ENABLE];
		end else begin
			comparator_on <= enable;
		end
	end

	always @(posedge clock) begin
		if (rst) begin
			positive_input_ref_select <= CTRL_RESET[`CMPCTL_BIT_POS_REF];
		end else begin
			positive_input_ref_select <= ctrl[`CMPCTL_BIT_POS_REF];
		end
	end

	always @(posedge clock) begin
		if (rst) begin
			negative_input_select <= ctrl_neg(CTRL_RESET);
		end else begin
			negative_input_select <= ctrl_neg(ctrl);
		end
	end

	// ----------------------------------------
	// Result pin
	// ----------------------------------------
	// Pin held low while undriven so no stale level leaks out
	always @(posedge clock) begin
		if (rst) begin
			result_pin <= 1'h0;
		end else begin
			result_pin <= result & pin_drive;
		end
	end

	always @(posedge clock) begin
		if (rst) begin
			result_pin_oe <= 1'h0;
		end else begin
			result_pin_oe <= pin_drive;
		end
	end

	// ----------------------------------------
	// Read data
	// ----------------------------------------
	// No guard after a disable write: software must leave that cycle quiet
	always @(posedge clock) begin
		if (rst) begin
			rdata <= WORD_ZERO;
		end else begin
			rdata <= next_rdata;
		end
	end

endmodule // cmpctl_top

// ===== testbench/cmpctl_asserts.sv
// Port checker for the comparator control block.
// Assumes a bind onto the top module.
`timescale 1ns/1ns
module cmpctl_asserts(input wire clock, rst, wr, rd, comparator_on, positive_input_ref_select,
	result_pin, result_pin_oe, compare_event, input wire [1:0] negative_input_select,
	input wire [3:0] addr, input wire [31:0] wdata, rdata);
	default clocking @(posedge clock); endclocking
	default disable iff (rst);
	wire w = wr & addr == 0;
	on_wr_a: assert property (w |=> ##1 comparator_on == $past(wdata[15], 2))
		else $error("on");
	oe_wr_a: assert property (w |=> ##1 result_pin_oe == $past(wdata[14], 2))
		else $error("oe");
	pos_wr_a: assert property (w |=> ##1 positive_input_ref_select == $past(wdata[4], 2))
		else $error("pos");
	neg_wr_a: assert property (w |=> ##1 negative_input_select == $past(wdata[1:0], 2))
		else $error("neg");
	pin_off_a: assert property (!result_pin_oe |-> !result_pin) else $error("pin");
	evt_pulse_a: assert property (compare_event |=> !compare_event) else $error("ev");
	unimpl_zero_a: assert property (!(rdata & 32'hFFFF1E2C)) else $error("rsv");
	rd_idle_a: assert property (!$past(rd) |-> !rdata) else $error("idle");
endmodule // cmpctl_asserts

// ===== testbench/cmpctl_analog.sv
// Analog comparator core model with its input pins.
// Assumes pin levels arrive as plain bits from the bench.
`timescale 1ns/1ns
module cmpctl_analog(input wire comparator_on, positive_input_ref_select,
	input wire [1:0] negative_input_select, pl, input wire [3:0] nl, output wire raw_result);
	// Off core idles low, since it draws no current
	assign raw_result = comparator_on & pl[positive_input_ref_select]
		& ~nl[negative_input_select];
endmodule // cmpctl_analog

// ===== testbench/tb_cmpctl_top.sv
// Bench: random control words with edge, mask and clear checks.
// Assumes the partner model and the bound checker.
`timescale 1ns/1ns
module tb_cmpctl_top;
	logic clock = 0, rst = 1, wr = 0, rd = 0, raw_result, comparator_on, result_pin, irq;
	logic positive_input_ref_select, result_pin_oe, compare_event;
	logic [1:0] negative_input_select, pl = 0;
	logic [3:0] addr = 0, nl = 0;
	logic [31:0] wdata = 0, rdata, w;
	integer seed = 79355, miscompares = 0, samples_checked = 0, n = 0, i, e;
	initial forever #2 clock = ~clock;
	always @(posedge clock) n <= n + (compare_event === 1'b1);
	cmpctl_top u_dut(.*);
	cmpctl_analog u_ana(.*);
	task note(input logic bad, input logic [31:0] g, x);
		samples_checked++;
		if (bad) begin
			miscompares++;
			$display("ERROR %0t got %h exp %h", $time, g, x);
		end
	endtask
	task chk(input logic [31:0] g, x);
		note(g !== x, g, x);
	endtask
	task chk_level(input logic g, x);
		note(g !== x, {31'h0, g}, {31'h0, x});
	endtask
	task chk_count(input integer g, x);
		note(g !== x, g, x);
	endtask
	function logic [31:0] exp_ctrl(input logic [31:0] v, input logic res);
		exp_ctrl = v & 32'h0000E0D3 | {res, 8'h00};
	endfunction
	task acc(input logic r, input logic [3:0] a, input logic [31:0] d, x);
		@(posedge clock) {addr, wdata, wr, rd} <= {a, d, !r, r};
		@(posedge clock) {wr, rd} <= 0;
		@(negedge clock) if (r) chk(rdata, x);
	endtask
	function logic exp_ev(input integer k);
		exp_ev = k[2] ? k[1] : k[0];
	endfunction
	task wrap_up;
		$display("checked %0d miscompares %0d", samples_checked, miscompares);
		if (!miscompares && samples_checked) $display("DONE - PASS");
		else $display("DONE - FAIL");
		$finish;
	endtask
	initial begin
		repeat (8) @(posedge clock);
		rst <= 0;
		acc(1, 0, 0, 32'hC3);
		acc(0, 12, -1, 0);
		acc(1, 12, 0, 0);
		for (i = 0; i < 8; i++) begin
			@(posedge clock) pl <= 0;
			// Spacing keeps setup edges apart from the measured one
			repeat (6) @(posedge clock);
			w = $random(seed) & 32'hFFFF5F3F | {2'h2, i[2], 5'h0, i[1:0], 6'h0};
			acc(0, 0, w, 0);
			acc(0, 8, i, 0);
			repeat (6) @(posedge clock);
			acc(0, 4, 1, 0);
			e = n;
			@(posedge clock) pl <= 3;
			repeat (8) @(posedge clock);
			@(negedge clock);
			chk_count(n - e, exp_ev(i));
			chk_level(irq, exp_ev(i) & i[0]);
			chk_level(result_pin_oe, w[14]);
			chk_level(result_pin, w[14] & !i[2]);
			acc(1, 0, 0, exp_ctrl(w, !i[2]));
		end
		// Disable, then keep the following cycle free of accesses
		acc(0, 0, 32'h00000003, 0);
		@(posedge clock);
		acc(1, 0, 0, 32'h00000003);
		chk_level(comparator_on, 0);
		// Mid-run reset must restore the power-on control word
		acc(0, 0, 32'hFFFFFFFF, 0);
		@(posedge clock) rst <= 1;
		repeat (2) @(posedge clock);
		rst <= 0;
		acc(1, 0, 0, 32'hC3);
		acc(1, 4, 0, 0);
		wrap_up;
	end
endmodule // tb_cmpctl_top
bind cmpctl_top cmpctl_asserts u_chk(.*);
